// *** include/block_seq_regs.vh ***
`ifndef BLOCK_SEQ_REGS_VH
`define BLOCK_SEQ_REGS_VH

// ============================================================
// Bus cycle type codes shown on cyc_type
`define CYC_N      2'h0
`define CYC_S      2'h1
`define CYC_I      2'h2

// ============================================================
// Addressing and sequencing constants
`define WORD_STEP  32'h00000004
`define PC_IDX     4'hf
`define CYC_WB     5'h01
`define MASK_ONE   16'h0001
`define LANE0      2'h0
`define LANE1      2'h1
`define LANE2      2'h2

`endif

// *** verilog/lowest_bit_finder.v ***
`default_nettype none

// ============================================================
// Lowest set bit of a mask and the number of set bits
module lowest_bit_finder #(
  parameter W  = 16,
  parameter IW = 4,
  parameter CW = 5
) (
  input  wire [W-1:0]  mask,
  output reg  [IW-1:0] idx,
  output reg           any,
  output reg  [CW-1:0] count
);
  integer i;

  // Scan from the top so the lowest set bit is the last to land
  always @* begin
    idx   = {IW{1'b0}};
    any   = 1'b0;
    count = {CW{1'b0}};
    for (i = W - 1; i >= 0; i = i - 1) begin
      if (mask[i]) begin
        idx = i[IW-1:0];
        any = 1'b1;
      end
      count = count + {{(CW-1){1'b0}}, mask[i]};
    end
  end
endmodule

`default_nettype wire

// *** verilog/block_addr_gen.v ***
`default_nettype none
`include "block_seq_regs.vh"

// ============================================================
// First transfer address and updated base for a block transfer
module block_addr_gen (
  input  wire [31:0] base,
  input  wire [4:0]  count,
  input  wire        pre,
  input  wire        up,
  output reg  [31:0] start_addr,
  output reg  [31:0] final_base
);
  wire [31:0] span;

  // Span of the whole block, four bytes per word
  assign span = {25'h0, count, 2'h0};

  // Lowest register always takes the lowest address, so a descending
  // block starts at the bottom of the span and climbs from there
  always @* begin
    if (up) begin
      final_base = base + span;
      start_addr = pre ? base + `WORD_STEP : base;
    end else begin
      final_base = base - span;
      start_addr = pre ? base - span : base - span + `WORD_STEP;
    end
  end
endmodule

`default_nettype wire

// *** verilog/block_swap_seq.v ***
// Contract
// - Base write-back lands at the end of the instruction's second cycle.
// - First store goes out in cycle two; later stored base shows updated value.
// - A load that lists the base beats the written-back base unless it aborts.
// - Block transfer abort handling ignores the delayed fault select input.
// - Aborted store runs to the end, then traps; only write-back changes.
// - Aborted load stops register writes from the aborting transfer onward.
// - Program counter is written last by a load, so aborts preserve it.
// - After aborted load the base is restored, to modified value if write-back.
// - Abort trap on a load only after all its cycles have run.
// - Load takes nS+1N+1I; with program counter (n+1)S+2N+1I.
// - Store of n words takes (n-1)S+2N cycles.
// - Direction, index and up bits select one of eight modes.
// - Full stacks pre-adjust, empty post-adjust; ascending stores go up.
// - Swap is one read then one write, inseparable.
// - Swap reads at base, writes source there, old value to destination.
// - Lock is high through the swap read and write cycles.
// - Swap byte select picks byte or word with endian handling.
// - Abort on either swap access traps, whatever the delayed fault select.
// - Swap takes 1S+2N+1I cycles.
// - Bit k of the sixteen-bit list selects register k.
// - Registers move in ascending order, lowest register at lowest address.
// - Single transfers use delayed fault select; block ops and swap do not.
`default_nettype none
`include "block_seq_regs.vh"

module block_swap_seq (
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  input  wire        start,
  input  wire        op_swap,
  input  wire        op_load,
  input  wire        op_pre,
  input  wire        op_up,
  input  wire        op_wback,
  input  wire        op_byte,
  input  wire        big_end,
  input  wire        delayed_fault_select,
  input  wire [15:0] reg_list,
  input  wire [3:0]  base_idx,
  input  wire [3:0]  src_idx,
  input  wire [3:0]  dst_idx,
  input  wire [31:0] base_val,
  output reg  [3:0]  rf_ridx,
  input  wire [31:0] rf_rdata,
  output reg         rf_we,
  output reg  [3:0]  rf_widx,
  output reg  [31:0] rf_wdata,
  output reg         base_we,
  output reg  [3:0]  base_widx,
  output reg  [31:0] base_wdata,
  output reg         mem_req,
  output reg         mem_write,
  output reg         mem_byte,
  output wire [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  input  wire [31:0] mem_rdata,
  input  wire        mem_abort,
  output reg  [1:0]  cyc_type,
  output reg         lock,
  output wire        busy,
  output reg         done,
  output reg         trap_abort
);
  // ============================================================
  // States, one-hot
  localparam [8:0] ST_IDLE  = 9'h001;
  localparam [8:0] ST_SETUP = 9'h002;
  localparam [8:0] ST_XFER  = 9'h004;
  localparam [8:0] ST_INT   = 9'h008;
  localparam [8:0] ST_FILL  = 9'h010;
  localparam [8:0] ST_SWADR = 9'h020;
  localparam [8:0] ST_SWRD  = 9'h040;
  localparam [8:0] ST_SWWR  = 9'h080;
  localparam [8:0] ST_SWINT = 9'h100;

  reg  [8:0]  state_r;
  reg  [4:0]  cyc_r;
  reg  [15:0] mask_r;
  reg  [31:0] addr_r;
  reg  [31:0] orig_r;
  reg  [31:0] final_r;
  reg  [31:0] sw_data_r;
  reg  [3:0]  base_r;
  reg  [3:0]  src_r;
  reg  [3:0]  dst_r;
  reg         load_r;
  reg         wback_r;
  reg         byte_r;
  reg         be_r;
  reg         base_in_r;
  reg         pc_in_r;
  reg         first_r;
  reg         abt_r;
  reg         wb_done_r;
  reg         fill_n_r;

  wire [3:0]  cur_idx;
  wire        cur_any;
  wire [4:0]  list_cnt;
  wire [31:0] start_addr;
  wire [31:0] final_base;
  wire [15:0] mask_left;
  wire        last_xfer;
  wire        abt_now;

  // ============================================================
  // Register selection and address generation
  lowest_bit_finder #(.W(16), .IW(4), .CW(5)) u_cur (
    .mask  (mask_r),
    .idx   (cur_idx),
    .any   (cur_any),
    .count ()
  );

  // Word count of the incoming list sizes the block
  lowest_bit_finder #(.W(16), .IW(4), .CW(5)) u_cnt (
    .mask  (reg_list),
    .idx   (),
    .any   (),
    .count (list_cnt)
  );

  // Mode bits pick direction and pre/post adjustment
  block_addr_gen u_addr (
    .base       (base_val),
    .count      (list_cnt),
    .pre        (op_pre),
    .up         (op_up),
    .start_addr (start_addr),
    .final_base (final_base)
  );

  // Retire the lowest remaining register each transfer
  assign mask_left = mask_r & ~(`MASK_ONE << cur_idx);
  assign last_xfer = (mask_left == 16'h0000) || !cur_any;
  assign abt_now   = abt_r | mem_abort;
  assign mem_addr  = addr_r;
  assign busy      = (state_r != ST_IDLE);

  // Byte lane extraction for a byte read, zero filled above
  function [31:0] pick_byte(input [31:0] w, input [1:0] a, input be);
    reg [1:0] lane;
    begin
      lane = be ? ~a : a;
      case (lane)
        `LANE0:  pick_byte = {24'h000000, w[7:0]};
        `LANE1:  pick_byte = {24'h000000, w[15:8]};
        `LANE2:  pick_byte = {24'h000000, w[23:16]};
        default: pick_byte = {24'h000000, w[31:24]};
      endcase
    end
  endfunction

  // ============================================================
  // Bus cycle decode from state
  // The delayed fault select input steers only single transfers, so
  // nothing here looks at it: block ops and swap abort alike either way
  always @* begin
    cyc_type  = `CYC_I;
    mem_req   = 1'b0;
    mem_write = 1'b0;
    mem_byte  = 1'b0;
    lock      = 1'b0;
    rf_ridx   = cur_idx;
    mem_wdata = 32'h00000000;
    case (state_r)
      ST_SETUP: begin
        cyc_type = `CYC_N;
      end
      ST_XFER: begin
        cyc_type  = first_r ? `CYC_N : `CYC_S;
        mem_req   = 1'b1;
        mem_write = !load_r;
        // The write-back is only seen by the register file a cycle late,
        // so a base stored after it is patched here
        if (cur_idx == base_r && wb_done_r) begin
          mem_wdata = final_r;
        end else begin
          mem_wdata = rf_rdata;
        end
      end
      ST_INT: begin
        cyc_type = `CYC_I;
      end
      ST_FILL: begin
        cyc_type = fill_n_r ? `CYC_N : `CYC_S;
      end
      ST_SWADR: begin
        cyc_type = `CYC_S;
      end
      ST_SWRD: begin
        cyc_type = `CYC_N;
        mem_req  = 1'b1;
        mem_byte = byte_r;
        lock     = 1'b1;
      end
      ST_SWWR: begin
        cyc_type  = `CYC_N;
        mem_req   = 1'b1;
        mem_write = 1'b1;
        mem_byte  = byte_r;
        lock      = 1'b1;
        rf_ridx   = src_r;
        // Byte stores repeat the low byte on every lane
        mem_wdata = byte_r ? {4{rf_rdata[7:0]}} : rf_rdata;
      end
      ST_SWINT: begin
        cyc_type = `CYC_I;
      end
      default: begin
        cyc_type = `CYC_I;
      end
    endcase
  end

  // ============================================================
  // Sequencer, register writes and abort tracking
  always @(posedge clk) begin
    if (!nrst) begin
      state_r    <= ST_IDLE;
      cyc_r      <= 5'h00;
      mask_r     <= 16'h0000;
      addr_r     <= 32'h00000000;
      orig_r     <= 32'h00000000;
      final_r    <= 32'h00000000;
      sw_data_r  <= 32'h00000000;
      base_r     <= 4'h0;
      src_r      <= 4'h0;
      dst_r      <= 4'h0;
      load_r     <= 1'b0;
      wback_r    <= 1'b0;
      byte_r     <= 1'b0;
      be_r       <= 1'b0;
      base_in_r  <= 1'b0;
      pc_in_r    <= 1'b0;
      first_r    <= 1'b0;
      abt_r      <= 1'b0;
      wb_done_r  <= 1'b0;
      fill_n_r   <= 1'b0;
      rf_we      <= 1'b0;
      rf_widx    <= 4'h0;
      rf_wdata   <= 32'h00000000;
      base_we    <= 1'b0;
      base_widx  <= 4'h0;
      base_wdata <= 32'h00000000;
      done       <= 1'b0;
      trap_abort <= 1'b0;
    end else if (ce) begin
      rf_we      <= 1'b0;
      base_we    <= 1'b0;
      done       <= 1'b0;
      trap_abort <= 1'b0;
      if (state_r != ST_IDLE) begin
        cyc_r <= cyc_r + 5'h01;
      end
      // Write-back at the end of cycle two; a load listing the base
      // skips it so the loaded value is the one that stays
      if (state_r != ST_IDLE && state_r != ST_SWADR && state_r != ST_SWRD &&
          state_r != ST_SWWR && state_r != ST_SWINT && cyc_r == `CYC_WB &&
          wback_r && !(load_r && base_in_r)) begin
        base_we    <= 1'b1;
        base_widx  <= base_r;
        base_wdata <= final_r;
        wb_done_r  <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            cyc_r     <= 5'h00;
            abt_r     <= 1'b0;
            wb_done_r <= 1'b0;
            first_r   <= 1'b1;
            base_r    <= base_idx;
            src_r     <= src_idx;
            dst_r     <= dst_idx;
            load_r    <= op_load;
            wback_r   <= op_wback && !op_swap;
            byte_r    <= op_byte;
            be_r      <= big_end;
            orig_r    <= base_val;
            final_r   <= final_base;
            mask_r    <= reg_list;
            base_in_r <= reg_list[base_idx];
            pc_in_r   <= reg_list[`PC_IDX];
            if (op_swap) begin
              addr_r  <= base_val;
              state_r <= ST_SWADR;
            end else begin
              addr_r  <= start_addr;
              state_r <= op_load ? ST_XFER : ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          state_r <= ST_XFER;
        end
        ST_XFER: begin
          first_r <= 1'b0;
          addr_r  <= addr_r + `WORD_STEP;
          mask_r  <= mask_left;
          abt_r   <= abt_now;
          // Ascending order makes the program counter the last write
          if (load_r && !abt_now) begin
            rf_we    <= 1'b1;
            rf_widx  <= cur_idx;
            rf_wdata <= mem_rdata;
          end
          if (last_xfer) begin
            if (load_r) begin
              state_r <= ST_INT;
            end else begin
              // Store keeps issuing its cycles after an abort and traps last
              state_r    <= ST_IDLE;
              done       <= 1'b1;
              trap_abort <= abt_now;
            end
          end
        end
        ST_INT: begin
          // Restore follows the last load write by at least two cycles, so it wins
          if (abt_r) begin
            base_we    <= 1'b1;
            base_widx  <= base_r;
            base_wdata <= wback_r ? final_r : orig_r;
          end
          fill_n_r <= pc_in_r;
          state_r  <= ST_FILL;
        end
        ST_FILL: begin
          // A program counter load spends one N and two S fill cycles
          if (fill_n_r) begin
            fill_n_r <= 1'b0;
          end else if (pc_in_r) begin
            pc_in_r <= 1'b0;
          end else begin
            state_r    <= ST_IDLE;
            done       <= 1'b1;
            trap_abort <= abt_r;
          end
        end
        ST_SWADR: begin
          state_r <= ST_SWRD;
        end
        ST_SWRD: begin
          sw_data_r <= byte_r ? pick_byte(mem_rdata, addr_r[1:0], be_r) : mem_rdata;
          abt_r     <= mem_abort;
          state_r   <= ST_SWWR;
        end
        ST_SWWR: begin
          abt_r <= abt_now;
          // Destination is written after the source was sent out, so the
          // two may name the same register
          if (!abt_r) begin
            rf_we    <= 1'b1;
            rf_widx  <= dst_r;
            rf_wdata <= sw_data_r;
          end
          state_r <= ST_SWINT;
        end
        ST_SWINT: begin
          state_r    <= ST_IDLE;
          done       <= 1'b1;
          trap_abort <= abt_r;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// *** verification/seq_check_sva.sv ***
`default_nettype none
`include "block_seq_regs.vh"

// ============================================================
// Sequencer checker, one clock domain
module seq_check (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        start,
  input wire logic        busy,
  input wire logic        op_swap,
  input wire logic        op_load,
  input wire logic        op_wback,
  input wire logic [3:0]  base_idx,
  input wire logic        mem_req,
  input wire logic        mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_abort,
  input wire logic        lock,
  input wire logic [1:0]  cyc_type,
  input wire logic        rf_we,
  input wire logic        base_we,
  input wire logic [3:0]  base_widx,
  input wire logic        done,
  input wire logic        trap_abort
);
  timeunit 1ns;
  timeprecision 100ps;
  // Checks assume ce held high by the bench
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_wb_time;
    start && !busy && !op_swap && !op_load && op_wback |->
      ##3 base_we && base_widx == $past(base_idx, 3);
  endproperty
  a_wb_time: assert property (p_wb_time) else $error("base write-back mistimed");
  property p_swap_seq;
    start && !busy && op_swap |-> ##2 (lock && !mem_write) ##1 (lock && mem_write) ##1 !lock;
  endproperty
  a_swap_seq: assert property (p_swap_seq) else $error("swap read/write order");
  property p_lock_bus;
    lock |-> mem_req && busy;
  endproperty
  a_lock_bus: assert property (p_lock_bus) else $error("lock outside transfer");
  property p_swap_addr;
    lock && !mem_write |=> mem_addr == $past(mem_addr);
  endproperty
  a_swap_addr: assert property (p_swap_addr) else $error("swap write address");
  property p_swap_type;
    lock && mem_write |-> cyc_type == `CYC_N;
  endproperty
  a_swap_type: assert property (p_swap_type) else $error("swap write cycle type");
  property p_swap_nowb;
    start && !busy && op_swap |=> !base_we [*4];
  endproperty
  a_swap_nowb: assert property (p_swap_nowb) else $error("swap wrote base");
  property p_ld_abort;
    mem_req && !mem_write && !lock && mem_abort |=> !rf_we [*2];
  endproperty
  a_ld_abort: assert property (p_ld_abort) else $error("load kept writing");
  property p_step;
    mem_req && !lock ##1 mem_req && !lock |-> mem_addr == $past(mem_addr) + `WORD_STEP;
  endproperty
  a_step: assert property (p_step) else $error("address step wrong");
  property p_trap;
    trap_abort |-> done;
  endproperty
  a_trap: assert property (p_trap) else $error("trap before end");
  property p_done;
    done |=> !done;
  endproperty
  a_done: assert property (p_done) else $error("done too long");
endmodule

bind block_swap_seq seq_check i_seq_check (
  .clk(clk), .nrst(nrst), .start(start), .busy(busy), .op_swap(op_swap),
  .op_load(op_load), .op_wback(op_wback), .base_idx(base_idx), .mem_req(mem_req),
  .mem_write(mem_write), .mem_addr(mem_addr), .mem_abort(mem_abort), .lock(lock),
  .cyc_type(cyc_type), .rf_we(rf_we), .base_we(base_we), .base_widx(base_widx),
  .done(done), .trap_abort(trap_abort));
`default_nettype wire

// *** verification/mem_partner.sv ***
`default_nettype none

// ============================================================
// Zero-wait memory with a one-address fault trigger
module mem_partner (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_write,
  input  wire logic        mem_byte,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic        big_end,
  input  wire logic        abort_en,
  input  wire logic [31:0] abort_addr,
  output wire logic [31:0] mem_rdata,
  output wire logic        mem_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [64];

  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 32'h5a000000 + i;
  end
  // Reject one address; bus is never taken away, so lock needs no arbiter
  assign mem_abort = abort_en && mem_req && mem_addr == abort_addr;
  // Read data shows the inverse of the word when no read is pending
  assign mem_rdata = (mem_req && !mem_write) ? mem[mem_addr[7:2]] : ~mem[mem_addr[7:2]];
  // Faulted stores never reach the array byte lane follows byte order
  always @(posedge clk) begin
    if (mem_req && mem_write && !mem_abort) begin
      if (mem_byte) mem[mem_addr[7:2]][8*(mem_addr[1:0] ^ {2{big_end}}) +: 8] <= mem_wdata[7:0];
      else mem[mem_addr[7:2]] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, nrst = 0, start = 0, abort_en = 0, tr, delayed_fault_select = 0, big_end = 0;
  logic op_swap = 0, op_load = 0, op_pre = 0, op_up = 0, op_wback = 0, op_byte = 0;
  logic [15:0] reg_list = 0;
  logic [3:0]  base_idx = 0, src_idx = 0, dst_idx = 0;
  logic [31:0] abort_addr = 0, rf [16];
  wire logic [3:0]  rf_ridx, rf_widx, base_widx;
  wire logic [31:0] rf_wdata, base_wdata, mem_addr, mem_wdata, mem_rdata;
  wire logic rf_we, base_we, mem_req, mem_write, mem_byte, mem_abort, lock, busy, done, trap_abort;
  wire logic [1:0] cyc_type;
  int bad_count = 0, check_count = 0, cyc = 0, k;

  block_swap_seq i_block_swap_seq (.clk(clk), .nrst(nrst), .ce(1'b1), .start(start),
    .op_swap(op_swap), .op_load(op_load), .op_pre(op_pre), .op_up(op_up),
    .op_wback(op_wback), .op_byte(op_byte), .big_end(big_end),
    .delayed_fault_select(delayed_fault_select), .reg_list(reg_list), .base_idx(base_idx),
    .src_idx(src_idx), .dst_idx(dst_idx), .base_val(rf[base_idx]), .rf_ridx(rf_ridx),
    .rf_rdata(rf[rf_ridx]), .rf_we(rf_we), .rf_widx(rf_widx), .rf_wdata(rf_wdata),
    .base_we(base_we), .base_widx(base_widx), .base_wdata(base_wdata), .mem_req(mem_req),
    .mem_write(mem_write), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_abort(mem_abort), .cyc_type(cyc_type), .lock(lock),
    .busy(busy), .done(done), .trap_abort(trap_abort));
  mem_partner i_mem_partner (.clk(clk), .mem_req(mem_req), .mem_write(mem_write),
    .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .abort_en(abort_en),
    .big_end(big_end), .abort_addr(abort_addr), .mem_rdata(mem_rdata), .mem_abort(mem_abort));

  // ============================================================
  // Clock, register file and hang guard
  initial forever #12.5 clk = ~clk;
  // Load port written after base port, so it wins on a clash
  always @(posedge clk) begin
    if (base_we) rf[base_widx] <= base_wdata;
    if (rf_we) rf[rf_widx] <= rf_wdata;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  function automatic logic [31:0] m0(input logic [31:0] a);
    return 32'h5a000000 + a[7:2];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic init_rf();
    for (int i = 0; i < 16; i++) rf[i] = 32'hb0000000 + i;
  endtask
  // Ops packed as swap, load, pre, up, wback, byte; counts edges from take to done
  task automatic run(input logic [5:0] ops, input logic [15:0] l, input logic [3:0] b, s, d);
    @(posedge clk);
    #1;
    {op_swap, op_load, op_pre, op_up, op_wback, op_byte} = ops;
    reg_list = l;
    base_idx = b;
    src_idx = s;
    dst_idx = d;
    start = 1;
    @(posedge clk);
    #1;
    start = 0;
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk({31'h0, done}, 32'h1);
    tr = trap_abort;
    abort_en = 0;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_store();
    init_rf();
    rf[2] = 32'h80;
    run(6'b000110, 16'h0006, 4'h2, 4'h0, 4'h0);
    chk(i_mem_partner.mem[32], 32'hb0000001);
    chk(i_mem_partner.mem[33], 32'h88);
    chk(rf[2], 32'h88);
    chk(32'(k), 32'd3);
    rf[2] = 32'h90;
    run(6'b001010, 16'h0024, 4'h2, 4'h0, 4'h0);
    chk(i_mem_partner.mem[34], 32'h90);
    chk(i_mem_partner.mem[35], 32'hb0000005);
    chk(rf[2], 32'h88);
  endtask
  task automatic t_load_modes();
    logic [31:0] a;
    for (int m = 0; m < 4; m++) begin
      init_rf();
      rf[6] = 32'h40;
      a = m[1] ? (m[0] ? 32'h44 : 32'h38) : (m[0] ? 32'h40 : 32'h3c);
      run({2'b01, m[1:0], 2'b00}, 16'h0018, 4'h6, 4'h0, 4'h0);
      chk(rf[3], m0(a));
      chk(rf[4], m0(a + 32'h4));
      chk(rf[6], 32'h40);
      chk(32'(k), 32'd4);
    end
    run(6'b010110, 16'h00c0, 4'h6, 4'h0, 4'h0);
    chk(rf[6], m0(32'h40));
  endtask
  task automatic t_load_abort(input logic dfs, input logic [31:0] ab);
    init_rf();
    rf[8] = 32'h40;
    delayed_fault_select = dfs;
    abort_addr = ab;
    abort_en = 1;
    run(6'b010110, 16'h8101, 4'h8, 4'h0, 4'h0);
    chk(rf[0], m0(32'h40));
    chk(rf[15], 32'hb000000f);
    chk(rf[8], 32'h4c);
    chk({31'h0, tr}, 32'h1);
    chk(32'(k), 32'd7);
  endtask
  task automatic t_store_abort();
    init_rf();
    rf[3] = 32'ha0;
    abort_addr = 32'ha0;
    abort_en = 1;
    run(6'b000110, 16'h0006, 4'h3, 4'h0, 4'h0);
    chk(i_mem_partner.mem[40], m0(32'ha0));
    chk(i_mem_partner.mem[41], 32'hb0000002);
    chk(rf[3], 32'ha8);
    chk({31'h0, tr}, 32'h1);
  endtask
  task automatic t_swap();
    init_rf();
    rf[4] = 32'hc0;
    run(6'b100000, 16'h0001, 4'h4, 4'h5, 4'h5);
    chk(rf[5], m0(32'hc0));
    chk(i_mem_partner.mem[48], 32'hb0000005);
    chk(32'(k), 32'd4);
    rf[4] = 32'hc7;
    run(6'b100001, 16'h0001, 4'h4, 4'h7, 4'h6);
    chk(rf[6], 32'h5a);
    chk(i_mem_partner.mem[49], 32'h07000031);
    rf[4] = 32'hc8;
    abort_addr = 32'hc8;
    abort_en = 1;
    run(6'b100000, 16'h0001, 4'h4, 4'h7, 4'h6);
    chk({31'h0, tr}, 32'h1);
    chk(rf[6], 32'h5a);
    chk(i_mem_partner.mem[50], m0(32'hc8));
    // Big-endian byte swap: offset zero is the top byte of the word
    big_end = 1;
    rf[4] = 32'hcc;
    run(6'b100001, 16'h0001, 4'h4, 4'h7, 4'h8);
    chk(rf[8], 32'h5a);
    chk(i_mem_partner.mem[51], 32'h07000033);
    big_end = 0;
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial begin
    init_rf();
    repeat (20) @(posedge clk);
    #1;
    nrst = 1;
    t_store();
    t_load_modes();
    t_load_abort(1'b0, 32'h48);
    t_load_abort(1'b1, 32'h44);
    t_store_abort();
    t_swap();
    stop_test();
  end
endmodule
`default_nettype wire
